// >>> rtl/flash_pwr_dev.sv
// flash end: samples the link, decodes power commands, tracks power state
`timescale 1ns/10ps
`default_nettype none
module flash_pwr_dev
	import flash_pwr_pkg::*;
#(
	parameter int unsigned DEEP_ENTRY = DEEP_ENTRY_CYC,
	parameter int unsigned DEEP_RESUME = DEEP_RESUME_CYC,
	parameter int unsigned ULTRA_ENTRY = ULTRA_ENTRY_CYC,
	parameter int unsigned ULTRA_EXIT = ULTRA_EXIT_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// serial link
	spi_link_if.dev link,
	// array side
	input wire logic busy_i,
	input wire logic [1:0] buf_wr_i,
	// state and decoded commands
	output var power_mode_e mode_o,
	output logic [1:0] buf_valid_o,
	output logic [7:0] cmd_o,
	output logic cmd_valid_o
);

	if (DEEP_ENTRY < 1 || DEEP_ENTRY >= 2**TIMER_W ||
		DEEP_RESUME < 1 || DEEP_RESUME >= 2**TIMER_W ||
		ULTRA_ENTRY < 1 || ULTRA_ENTRY >= 2**TIMER_W ||
		ULTRA_EXIT < 1 || ULTRA_EXIT >= 2**TIMER_W) begin : g_chk
		$error("flash_pwr_dev: timer count out of range");
	end

	typedef enum logic [2:0] {
		st_standby,
		st_deep_entry,
		st_deep,
		st_deep_resume,
		st_ultra_entry,
		st_ultra,
		st_ultra_wake,
		st_ultra_exit
	} dev_state_e;

	localparam logic [TIMER_W-1:0] T_DEEP_ENTRY = TIMER_W'(DEEP_ENTRY - 1);
	localparam logic [TIMER_W-1:0] T_DEEP_RESUME = TIMER_W'(DEEP_RESUME - 1);
	localparam logic [TIMER_W-1:0] T_ULTRA_ENTRY = TIMER_W'(ULTRA_ENTRY - 1);
	localparam logic [TIMER_W-1:0] T_ULTRA_EXIT = TIMER_W'(ULTRA_EXIT - 1);

	logic [SYNC_STAGES-1:0] cs_sy_q;
	logic [SYNC_STAGES-1:0] sck_sy_q;
	logic [SYNC_STAGES-1:0] mosi_sy_q;
	logic cs_f_q;
	logic sck_f_q;
	logic mosi_f_q;
	logic cs_f_d;
	logic sck_f_d;
	logic mosi_f_d;

	// a level counts once the second and third stages agree
	assign cs_f_d = (cs_sy_q[1] == cs_sy_q[2]) ? cs_sy_q[2] : cs_f_q;
	assign sck_f_d = (sck_sy_q[1] == sck_sy_q[2]) ? sck_sy_q[2] : sck_f_q;
	assign mosi_f_d = (mosi_sy_q[1] == mosi_sy_q[2]) ? mosi_sy_q[2] :
		mosi_f_q;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cs_sy_q <= '1;
			sck_sy_q <= '0;
			mosi_sy_q <= '0;
			cs_f_q <= 1'b1;
			sck_f_q <= 1'b0;
			mosi_f_q <= 1'b0;
		end else begin
			cs_sy_q <= {cs_sy_q[SYNC_STAGES-2:0], link.cs_n};
			sck_sy_q <= {sck_sy_q[SYNC_STAGES-2:0], link.sck};
			mosi_sy_q <= {mosi_sy_q[SYNC_STAGES-2:0], link.mosi};
			cs_f_q <= cs_f_d;
			sck_f_q <= sck_f_d;
			mosi_f_q <= mosi_f_d;
		end
	end

	logic cs_fall;
	logic cs_rise;
	logic sck_rise;
	assign cs_fall = cs_f_q & ~cs_f_d;
	assign cs_rise = ~cs_f_q & cs_f_d;
	assign sck_rise = ~sck_f_q & sck_f_d & ~cs_f_q;

	// bit counter and first-byte capture
	logic [2:0] bits_q;
	logic got_q;
	logic [6:0] sh_q;
	logic [7:0] op_q;
	logic sel_ok_q;
	dev_state_e state_q;
	dev_state_e state_d;
	logic [TIMER_W-1:0] tmr_q;
	logic [TIMER_W-1:0] tmr_d;
	logic tmr_zero;

	logic byte_done;
	logic [7:0] first_op;
	logic clean_end;
	logic sel_ok_d;
	assign byte_done = sck_rise & (bits_q == 3'h7) & ~got_q;
	assign first_op = {sh_q, mosi_f_d};
	// only selects begun in a listening state may carry a command
	assign sel_ok_d = (state_q == st_standby) | (state_q == st_deep);
	// a command counts only if a whole opcode arrived and bits are aligned
	assign clean_end = cs_rise & sel_ok_q & got_q & (bits_q == 3'h0);
	assign tmr_zero = (tmr_q == '0);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bits_q <= 3'h0;
			got_q <= 1'b0;
			sh_q <= 7'h00;
			op_q <= 8'h00;
			sel_ok_q <= 1'b0;
		end else if (cs_fall) begin
			bits_q <= 3'h0;
			got_q <= 1'b0;
			sel_ok_q <= sel_ok_d;
		end else if (sck_rise) begin
			bits_q <= bits_q + 3'h1;
			if (!got_q) begin
				sh_q <= first_op[6:0];
			end
			if (byte_done) begin
				got_q <= 1'b1;
				op_q <= first_op;
			end
		end
	end

	logic is_deep_op;
	logic is_resume_op;
	logic is_ultra_op;
	logic enter_deep;
	logic enter_ultra;
	assign is_deep_op = (op_q == OP_DEEP_ENTER);
	assign is_resume_op = (op_q == OP_DEEP_RESUME);
	assign is_ultra_op = (op_q == OP_ULTRA_ENTER);
	assign enter_deep = clean_end & is_deep_op & ~busy_i;
	assign enter_ultra = clean_end & is_ultra_op & ~busy_i;

	always_comb begin
		state_d = state_q;
		tmr_d = tmr_zero ? tmr_q : tmr_q - TIMER_W'(1);
		unique case (state_q)
			st_standby: begin
				if (enter_deep) begin
					state_d = st_deep_entry;
					tmr_d = T_DEEP_ENTRY;
				end else if (enter_ultra) begin
					state_d = st_ultra_entry;
					tmr_d = T_ULTRA_ENTRY;
				end
			end
			st_deep_entry: begin
				if (tmr_zero) begin
					state_d = st_deep;
				end
			end
			st_deep: begin
				if (clean_end && is_resume_op) begin
					state_d = st_deep_resume;
					tmr_d = T_DEEP_RESUME;
				end
			end
			st_deep_resume: begin
				if (tmr_zero) begin
					state_d = st_standby;
				end
			end
			st_ultra_entry: begin
				if (tmr_zero) begin
					state_d = st_ultra;
				end
			end
			st_ultra: begin
				if (cs_fall) begin
					state_d = st_ultra_wake;
				end
			end
			st_ultra_wake: begin
				if (cs_rise) begin
					state_d = st_ultra_exit;
					tmr_d = T_ULTRA_EXIT;
				end
			end
			st_ultra_exit: begin
				if (tmr_zero) begin
					state_d = st_standby;
				end
			end
		endcase
	end

	// standby only when idle and deselected
	power_mode_e mode_d;
	always_comb begin
		unique case (state_q)
			st_standby: mode_d = (!cs_f_q || busy_i) ? pm_active : pm_standby;
			st_deep_entry, st_ultra_entry: mode_d = pm_active;
			st_deep, st_deep_resume: mode_d = pm_deep;
			st_ultra, st_ultra_wake, st_ultra_exit: mode_d = pm_ultra;
		endcase
	end

	logic pass_cmd;
	assign pass_cmd = byte_done & sel_ok_q & (state_q == st_standby) &
		(first_op != OP_DEEP_ENTER) & (first_op != OP_ULTRA_ENTER);

	logic [1:0] buf_valid_d;
	assign buf_valid_d = (enter_ultra ? 2'h0 : buf_valid_o) |
		((state_q == st_standby) ? buf_wr_i : 2'h0);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= st_standby;
			tmr_q <= '0;
			mode_o <= pm_standby;
			buf_valid_o <= 2'h0;
			cmd_o <= 8'h00;
			cmd_valid_o <= 1'b0;
		end else begin
			state_q <= state_d;
			tmr_q <= tmr_d;
			mode_o <= mode_d;
			buf_valid_o <= buf_valid_d;
			cmd_valid_o <= pass_cmd;
			if (pass_cmd) begin
				cmd_o <= first_op;
			end
		end
	end

endmodule
`default_nettype wire

// >>> rtl/flash_pwr_pkg.sv
// constants and types shared by both ends of the power-state link
package flash_pwr_pkg;

	localparam int unsigned CLK_MHZ = 20;
	// link timing, figures in ns
	localparam int unsigned DEEP_SLEEP_ENTRY_TIME_NS = 3000;
	localparam int unsigned DEEP_SLEEP_RESUME_TIME_NS = 35000;
	localparam int unsigned ULTRA_SLEEP_ENTRY_TIME_NS = 3000;
	localparam int unsigned WAKE_PULSE_MIN_LOW_TIME_NS = 20000;
	localparam int unsigned ULTRA_SLEEP_EXIT_TIME_NS = 100000;

	// longest times round down, least times round up, never below one
	function automatic int unsigned max_cyc(input int unsigned ns);
		int unsigned c;
		c = ns * CLK_MHZ / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int unsigned min_cyc(input int unsigned ns);
		int unsigned c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int unsigned DEEP_ENTRY_CYC = max_cyc(DEEP_SLEEP_ENTRY_TIME_NS);
	localparam int unsigned DEEP_RESUME_CYC =
		max_cyc(DEEP_SLEEP_RESUME_TIME_NS);
	localparam int unsigned ULTRA_ENTRY_CYC =
		max_cyc(ULTRA_SLEEP_ENTRY_TIME_NS);
	localparam int unsigned WAKE_LOW_CYC = min_cyc(WAKE_PULSE_MIN_LOW_TIME_NS);
	localparam int unsigned ULTRA_EXIT_CYC = max_cyc(ULTRA_SLEEP_EXIT_TIME_NS);

	// pin sampling depth and the lag it adds at the device
	localparam int unsigned SYNC_STAGES = 3;
	localparam int unsigned SYNC_LAG_CYC = 4;
	// host serial clock: half period in clk cycles
	localparam int unsigned SCK_HALF_CYC = 4;
	localparam int unsigned TIMER_W = 16;

	localparam logic [7:0] OP_DEEP_ENTER = 8'hb9;
	localparam logic [7:0] OP_DEEP_RESUME = 8'hab;
	localparam logic [7:0] OP_ULTRA_ENTER = 8'h79;
	localparam logic [7:0] OP_DUMMY = 8'h00;

	typedef enum logic [1:0] {
		pm_standby,
		pm_active,
		pm_deep,
		pm_ultra
	} power_mode_e;

	typedef enum logic [2:0] {
		hc_deep_enter,
		hc_deep_resume,
		hc_ultra_enter,
		hc_ultra_wake,
		hc_other
	} host_cmd_e;

endpackage

// >>> rtl/spi_link_if.sv
// serial link between host controller and flash power-state logic
`timescale 1ns/10ps
`default_nettype none
interface spi_link_if;
	logic cs_n;
	logic sck;
	logic mosi;

	modport dev (
		input cs_n,
		input sck,
		input mosi
	);

	modport host (
		output cs_n,
		output sck,
		output mosi
	);
endinterface
`default_nettype wire

// >>> rtl/flash_pwr_host.sv
// host end: sends power commands and wake pulses, waits out the limits
`timescale 1ns/10ps
`default_nettype none
module flash_pwr_host
	import flash_pwr_pkg::*;
#(
	parameter int unsigned HALF = SCK_HALF_CYC,
	parameter int unsigned WAKE_LOW = WAKE_LOW_CYC,
	parameter int unsigned ULTRA_EXIT = ULTRA_EXIT_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// serial link
	spi_link_if.host link,
	// user request
	input wire logic req_i,
	input wire host_cmd_e cmd_i,
	input wire logic [7:0] opcode_i,
	input wire logic busy_i,
	// status
	output logic ready_o,
	output logic done_o
);

	if (HALF < 2 || HALF >= 2**TIMER_W || WAKE_LOW < 1 ||
		WAKE_LOW >= 2**TIMER_W || ULTRA_EXIT + SYNC_LAG_CYC >= 2**TIMER_W)
	begin : g_chk
		$error("flash_pwr_host: count out of range");
	end

	typedef enum logic [2:0] {
		h_idle,
		h_wait_busy,
		h_shift,
		h_hold,
		h_wake,
		h_settle
	} host_state_e;

	localparam logic [TIMER_W-1:0] T_HALF = TIMER_W'(HALF - 1);
	localparam logic [TIMER_W-1:0] T_WAKE = TIMER_W'(WAKE_LOW - 1);

	host_state_e state_q;
	host_cmd_e cmd_q;
	logic [7:0] sh_q;
	logic [2:0] bit_q;
	logic [TIMER_W-1:0] tmr_q;
	logic cs_n_q;
	logic sck_q;
	logic tmr_zero;
	logic entry_cmd;
	logic [7:0] tx_op;
	logic [TIMER_W-1:0] settle;

	assign link.cs_n = cs_n_q;
	assign link.sck = sck_q;
	assign link.mosi = sh_q[7];
	assign tmr_zero = (tmr_q == '0);
	assign entry_cmd = (cmd_i == hc_deep_enter) | (cmd_i == hc_ultra_enter);
	assign tx_op = (cmd_i == hc_deep_enter) ? OP_DEEP_ENTER :
		(cmd_i == hc_deep_resume) ? OP_DEEP_RESUME :
		(cmd_i == hc_ultra_enter) ? OP_ULTRA_ENTER : opcode_i;
	// wait out each limit plus sampling lag
	assign settle = (cmd_q == hc_deep_enter) ?
		TIMER_W'(DEEP_ENTRY_CYC + SYNC_LAG_CYC) :
		(cmd_q == hc_deep_resume) ? TIMER_W'(DEEP_RESUME_CYC + SYNC_LAG_CYC) :
		(cmd_q == hc_ultra_enter) ? TIMER_W'(ULTRA_ENTRY_CYC + SYNC_LAG_CYC) :
		(cmd_q == hc_ultra_wake) ? TIMER_W'(ULTRA_EXIT + SYNC_LAG_CYC) :
		TIMER_W'(SYNC_LAG_CYC);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= h_idle;
			cmd_q <= hc_other;
			sh_q <= 8'h00;
			bit_q <= 3'h0;
			tmr_q <= '0;
			cs_n_q <= 1'b1;
			sck_q <= 1'b0;
			ready_o <= 1'b1;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			tmr_q <= tmr_zero ? tmr_q : tmr_q - TIMER_W'(1);
			unique case (state_q)
				h_idle: begin
					if (req_i) begin
						ready_o <= 1'b0;
						cmd_q <= cmd_i;
						sh_q <= (cmd_i == hc_ultra_wake) ? OP_DUMMY : tx_op;
						if (entry_cmd && busy_i) begin
							state_q <= h_wait_busy;
						end else begin
							cs_n_q <= 1'b0;
							tmr_q <= (cmd_i == hc_ultra_wake) ? T_WAKE : T_HALF;
							bit_q <= 3'h7;
							state_q <= (cmd_i == hc_ultra_wake) ? h_wake : h_shift;
						end
					end
				end
				h_wait_busy: begin
					if (!busy_i) begin
						cs_n_q <= 1'b0;
						tmr_q <= T_HALF;
						bit_q <= 3'h7;
						state_q <= h_shift;
					end
				end
				h_shift: begin
					// eight bits, msb first, mode 0
					if (tmr_zero) begin
						tmr_q <= T_HALF;
						sck_q <= ~sck_q;
						if (sck_q) begin
							sh_q <= {sh_q[6:0], 1'b0};
							bit_q <= bit_q - 3'h1;
							if (bit_q == 3'h0) begin
								state_q <= h_hold;
							end
						end
					end
				end
				h_hold: begin
					if (tmr_zero) begin
						cs_n_q <= 1'b1;
						tmr_q <= settle;
						state_q <= h_settle;
					end
				end
				h_wake: begin
					// select held low the least time
					if (tmr_zero) begin
						cs_n_q <= 1'b1;
						tmr_q <= settle;
						state_q <= h_settle;
					end
				end
				h_settle: begin
					if (tmr_zero) begin
						ready_o <= 1'b1;
						done_o <= 1'b1;
						state_q <= h_idle;
					end
				end
				default: begin
					state_q <= h_idle;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// >>> test/flash_pwr_properties.sv
// concurrent checks on the link joining the host and device ends
`timescale 1ns/10ps
`default_nettype none
module flash_pwr_properties
	import flash_pwr_pkg::*;
#(
	parameter int DEEP_ENTRY = 8,
	parameter int DEEP_RESUME = 12,
	parameter int ULTRA_ENTRY = 8,
	parameter int ULTRA_EXIT = 16,
	parameter int WAKE_LOW = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// link wires
	input wire logic cs_n,
	input wire logic sck,
	input wire logic mosi,
	// device side
	input wire logic busy_i,
	input wire power_mode_e mode_o,
	input wire logic [1:0] buf_valid_o,
	input wire logic cmd_valid_o
);
	// slack covers the pin samplers and the state update
	localparam int DE_MAX = DEEP_ENTRY + 10;
	localparam int DR_MAX = DEEP_RESUME + 10;
	localparam int UE_MAX = ULTRA_ENTRY + 10;
	localparam int UX_MAX = ULTRA_EXIT + 10;
	logic sck_q;
	logic cs_q;
	logic [4:0] nbit_q;
	logic [7:0] byte_q;
	logic [5:0] low_q;
	logic [5:0] act_q;
	power_mode_e start_q;
	wire sck_rise = sck && !sck_q;
	wire cs_fall = !cs_n && cs_q;
	wire idle_active = mode_o == pm_active && cs_n && !busy_i;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sck_q <= 1'b0;
			cs_q <= 1'b1;
			start_q <= pm_standby;
		end else begin
			sck_q <= sck;
			cs_q <= cs_n;
			if (cs_fall)
				start_q <= mode_o;
		end
	end

	// bit count and first byte of the current select
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			nbit_q <= 5'h00;
			byte_q <= 8'h00;
		end else if (cs_fall) begin
			nbit_q <= 5'h00;
			byte_q <= 8'h00;
		end else if (sck_rise && !cs_n && nbit_q != 5'h1f) begin
			nbit_q <= nbit_q + 5'h01;
			if (nbit_q < 5'h08)
				byte_q <= {byte_q[6:0], mosi};
		end
	end

	// saturating run lengths, so long waits never wrap
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			low_q <= 6'h00;
			act_q <= 6'h00;
		end else begin
			low_q <= cs_n ? 6'h00 : low_q + {5'h00, low_q != 6'h3f};
			act_q <= idle_active ? act_q + {5'h00, act_q != 6'h3f} : 6'h00;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence clean_end(logic [7:0] op);
		$rose(cs_n) && nbit_q[2:0] == 3'h0 && nbit_q != 5'h00 && byte_q == op;
	endsequence

	sequence from_standby;
		start_q == pm_standby && !busy_i;
	endsequence

	a_reset_standby: assert property (
		$rose(reset_n_i) |-> mode_o == pm_standby && buf_valid_o == 2'b00)
		else $error("state wrong after reset");
	a_idle_standby: assert property (act_q < 6'h28)
		else $error("active while idle");
	a_deep_entry: assert property (
		clean_end(OP_DEEP_ENTER) ##0 from_standby
		|-> ##[1:DE_MAX] mode_o == pm_deep)
		else $error("deep entry late");
	a_resume_exit: assert property (
		clean_end(OP_DEEP_RESUME) ##0 start_q == pm_deep
		|-> ##[1:DR_MAX] mode_o == pm_standby)
		else $error("resume late");
	a_ultra_entry: assert property (
		clean_end(OP_ULTRA_ENTER) ##0 from_standby
		|-> ##[1:UE_MAX] mode_o == pm_ultra)
		else $error("ultra entry late");
	a_ultra_buffers: assert property (
		mode_o == pm_ultra |-> buf_valid_o == 2'b00)
		else $error("buffers kept in ultra");
	a_busy_blocks: assert property (
		$rose(cs_n) && busy_i && start_q != pm_deep
		|-> ##DE_MAX mode_o inside {pm_standby, pm_active})
		else $error("entry taken while busy");
	a_ultra_exit: assert property (
		mode_o == pm_ultra && $rose(cs_n) |-> ##[1:UX_MAX] mode_o == pm_standby)
		else $error("ultra exit late");
	a_cmd_gate: assert property (
		cmd_valid_o |-> start_q == pm_standby)
		else $error("command passed in sleep");
	a_wake_low: assert property (
		mode_o == pm_ultra && $rose(cs_n) |-> int'(low_q) >= WAKE_LOW)
		else $error("wake pulse too short");
endmodule
`default_nettype wire

// >>> test/serial_flash_power_down_modes_bench.sv
// bench: host and device ends face to face, plus a hand-driven device
`timescale 1ns/10ps
`default_nettype none
module serial_flash_power_down_modes_bench
	import flash_pwr_pkg::*;
;
	localparam int unsigned DE = 8;
	localparam int unsigned DR = 12;
	localparam int unsigned UX = 16;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic req_i = 1'b0;
	logic dbusy = 1'b0;
	logic [1:0] buf_wr = 2'b00;
	host_cmd_e cmd = hc_other;
	logic [7:0] op = 8'h00;
	power_mode_e mode;
	power_mode_e mode2;
	logic [1:0] bv;
	logic [7:0] cmd_o;
	logic cv;
	logic cv2;
	logic done;
	logic rdy;
	logic hbusy = 1'b0;
	logic [7:0] last_cmd = 8'h00;
	int n_cmd2 = 0;
	int mismatches = 0;
	int n_tests = 0;
	spi_link_if lk();
	spi_link_if lk2();

	flash_pwr_dev #(.DEEP_ENTRY(DE), .DEEP_RESUME(DR), .ULTRA_ENTRY(DE),
		.ULTRA_EXIT(UX)) u_flash_pwr_dev (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.link(lk.dev), .busy_i(dbusy), .buf_wr_i(buf_wr), .mode_o(mode),
		.buf_valid_o(bv), .cmd_o(cmd_o), .cmd_valid_o(cv));
	flash_pwr_dev #(.DEEP_ENTRY(DE), .DEEP_RESUME(DR), .ULTRA_ENTRY(DE),
		.ULTRA_EXIT(UX)) u_flash_pwr_dev_b (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.link(lk2.dev), .busy_i(dbusy), .buf_wr_i(buf_wr), .mode_o(mode2),
		.buf_valid_o(), .cmd_o(), .cmd_valid_o(cv2));
	flash_pwr_host #(.HALF(4), .WAKE_LOW(8), .ULTRA_EXIT(UX)) u_flash_pwr_host (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .link(lk.host), .req_i(req_i),
		.cmd_i(cmd), .opcode_i(op), .busy_i(hbusy), .ready_o(rdy),
		.done_o(done));
	flash_pwr_properties #(.DEEP_ENTRY(DE), .DEEP_RESUME(DR), .ULTRA_ENTRY(DE),
		.ULTRA_EXIT(UX), .WAKE_LOW(8)) u_props (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .cs_n(lk.cs_n), .sck(lk.sck), .mosi(lk.mosi),
		.busy_i(dbusy), .mode_o(mode), .buf_valid_o(bv), .cmd_valid_o(cv));

	always #25 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		if (cv === 1'b1)
			last_cmd <= cmd_o;
		if (cv2 === 1'b1)
			n_cmd2 <= n_cmd2 + 1;
	end

	task close_out;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task chk_mode(input string n, input power_mode_e e, input power_mode_e g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %0d seen %0d", n, e, g);
		end
	endtask

	task chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task run(input host_cmd_e c, input logic [7:0] o);
		int i;
		@(negedge clk_i);
		req_i = 1'b1;
		cmd = c;
		op = o;
		@(negedge clk_i);
		req_i = 1'b0;
		for (i = 0; i < 3000 && done !== 1'b1; i++)
			@(negedge clk_i);
		// device state lags the host's settle count by a few samples
		repeat (4) @(negedge clk_i);
		// a host stuck past the limit shows up as not ready
		chk_byte("ready", 8'h01, {7'h00, rdy});
	endtask

	// hand-driven frame: n bits msb first, then w idle cycles
	task bang(input logic [15:0] d, input int n, input int w);
		int i;
		@(negedge clk_i);
		lk2.cs_n = 1'b0;
		for (i = 0; i < n; i++) begin
			lk2.mosi = d[n - 1 - i];
			repeat (4) @(negedge clk_i);
			lk2.sck = 1'b1;
			repeat (4) @(negedge clk_i);
			lk2.sck = 1'b0;
		end
		repeat (4) @(negedge clk_i);
		lk2.cs_n = 1'b1;
		lk2.mosi = ~lk2.mosi;
		repeat (w) @(negedge clk_i);
	endtask

	initial begin
		lk2.cs_n = 1'b1;
		lk2.sck = 1'b0;
		lk2.mosi = 1'b0;
		repeat (16) @(negedge clk_i);
		reset_n_i = 1'b1;
		repeat (4) @(negedge clk_i);
		chk_mode("mode", pm_standby, mode);
		chk_mode("mode b", pm_standby, mode2);
		chk_byte("buffers", 8'h00, {6'h00, bv});
		buf_wr = 2'b11;
		@(negedge clk_i);
		buf_wr = 2'b00;
		run(hc_other, 8'h0b);
		chk_byte("opcode", 8'h0b, last_cmd);
		run(hc_deep_enter, 8'h00);
		chk_mode("deep", pm_deep, mode);
		run(hc_other, 8'hd7);
		chk_byte("opcode in deep", 8'h0b, last_cmd);
		run(hc_deep_resume, 8'h00);
		chk_mode("resumed", pm_standby, mode);
		// host must hold an entry while busy and send it once idle
		hbusy = 1'b1;
		fork
			run(hc_deep_enter, 8'h00);
			begin
				repeat (50) @(negedge clk_i);
				chk_mode("held busy", pm_standby, mode);
				chk_byte("host waits", 8'h00, {7'h00, rdy});
				hbusy = 1'b0;
			end
		join
		chk_mode("reissued", pm_deep, mode);
		run(hc_deep_resume, 8'h00);
		chk_mode("resumed again", pm_standby, mode);
		$display("test deep ended");
		for (int k = 0; k < 2; k++) begin
			dbusy = 1'b1;
			run(k == 0 ? hc_deep_enter : hc_ultra_enter, 8'h00);
			chk_mode("busy entry", pm_active, mode);
			dbusy = 1'b0;
			repeat (30) @(negedge clk_i);
			chk_mode("after busy", pm_standby, mode);
		end
		chk_byte("buffers", 8'h03, {6'h00, bv});
		run(hc_ultra_enter, 8'h00);
		chk_mode("ultra", pm_ultra, mode);
		chk_byte("buffers", 8'h00, {6'h00, bv});
		run(hc_ultra_wake, 8'h00);
		chk_mode("woken", pm_standby, mode);
		chk_byte("buffers", 8'h00, {6'h00, bv});
		buf_wr = 2'b01;
		@(negedge clk_i);
		buf_wr = 2'b00;
		@(negedge clk_i);
		chk_byte("rewritten", 8'h01, {6'h00, bv});
		run(hc_ultra_enter, 8'h00);
		chk_mode("ultra again", pm_ultra, mode);
		// any select is a wake pulse here, so the resume only wakes
		run(hc_deep_resume, 8'h00);
		chk_byte("resume in ultra", 8'h0b, last_cmd);
		chk_mode("woken by frame", pm_standby, mode);
		$display("test ultra ended");
		bang(16'h005c, 7, 40);
		chk_mode("short entry", pm_standby, mode2);
		bang(16'h0172, 9, 40);
		chk_mode("unaligned entry", pm_standby, mode2);
		bang(16'hb900, 16, 40);
		chk_mode("deep b", pm_deep, mode2);
		bang(16'h0055, 7, 40);
		chk_mode("short resume", pm_deep, mode2);
		bang(16'hab00, 16, 40);
		chk_mode("resume b", pm_standby, mode2);
		bang(16'h0079, 8, 40);
		chk_mode("ultra b", pm_ultra, mode2);
		bang(16'h000b, 8, 1);
		bang(16'hb900, 16, 40);
		chk_mode("early select", pm_standby, mode2);
		chk_byte("decoded b", 8'h00, 8'(n_cmd2));
		$display("test driven end ended");
		close_out();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		close_out();
	end
endmodule
`default_nettype wire
